// ===== src/spm_mapper.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module spm_mapper
    import spm_pkg::*;
#(
    parameter int unsigned AXI_ADDR_W = AXI_AW
) (
    input wire logic clk,
    input wire logic reset_n,
    // Processor request
    input wire spm_req_s cpuReq,
    // Interrupt acknowledge vector from the ISA bridge
    input wire logic [31:0] intAckVector,
    input wire logic intAckValid,
    // PCI cycle out and local register access out
    output spm_pci_s pciCycle,
    output spm_local_s localAccess,
    output logic [31:0] cpuReadData,
    output logic cpuReadValid,
    output logic decodeError,
    // AXI4-Lite slave
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Active-low byte enables from size and offset
    function automatic logic [3:0] byte_enables(input logic [1:0] sz, input logic [1:0] ofs);
        logic [3:0] be;
        be = BE_ALL;
        case (sz)
            SZ_BYTE: be = ~(4'h1 << ofs);
            SZ_WORD: be = ~(4'(4'h3 << ofs));
            SZ_TRI: be = ~(4'(4'h7 << ofs));
            default: be = BE_ALL;
        endcase
        return be;
    endfunction : byte_enables

    // Low address bits for sparse space; longword and quadword forced aligned
    function automatic logic [2:0] low_ad(input logic [CPU_AW-1:0] a);
        logic [2:0] r;
        r = {a[7], a[6:5]};
        if (a[4:3] == SZ_LONG && a[6:5] == OFS_QUAD) begin
            r = 3'h0;
        end else if (a[4:3] == SZ_LONG) begin
            r = {a[7], 2'h0};
        end
        return r;
    endfunction : low_ad

    // Byte-lane update for 32-bit registers
    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] memExt_q;
    logic [31:0] ioExt_q;
    logic [1:0] cfgType_q;
    logic [31:0] lastAd_q;
    spm_cycle_e lastCycle_q;
    logic lastBurst_q;
    logic [3:0] lastBe_q;
    logic [AXI_ADDR_W-1:0] awAddr_q;
    logic awHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHeld_q;

    // ------------------------------------------------------------
    // Single-stage address decode
    // ------------------------------------------------------------
    spm_cycle_e cycleD;
    logic [31:0] adD;
    logic [3:0] beD;
    logic burstD;
    logic [CPU_AW-1:0] a;
    logic [1:0] sz;
    logic [1:0] ofs;

    assign a = cpuReq.addr;
    assign sz = a[4:3];
    assign ofs = a[6:5];

    // Picks one cycle type and builds the PCI address
    always_comb begin
        cycleD = CYC_NONE;
        adD = 32'h0;
        beD = byte_enables(sz, ofs);
        burstD = 1'b0;
        if (a[39:34] == TOP_MEM_R1) begin
            cycleD = cpuReq.write ? CYC_MEM_WR : CYC_MEM_RD;
            adD = {memExt_q[31:29], a[33:31], a[30:8], low_ad(a)};
            adD[1:0] = 2'h0;
        end else if (a[39:32] == TOP_MEM_R2) begin
            cycleD = cpuReq.write ? CYC_MEM_WR : CYC_MEM_RD;
            adD = {memExt_q[15:11], a[31], a[30:8], low_ad(a)};
            adD[1:0] = 2'h0;
        end else if (a[39:31] == TOP_MEM_R3) begin
            cycleD = cpuReq.write ? CYC_MEM_WR : CYC_MEM_RD;
            adD = {memExt_q[7:2], a[30:8], low_ad(a)};
            adD[1:0] = 2'h0;
        end else if (a[39:31] == TOP_IO) begin
            cycleD = cpuReq.write ? CYC_IO_WR : CYC_IO_RD;
            if (a[34:30] == IO_REGION_A) begin
                adD = {7'h00, a[29:8], low_ad(a)};
            end else begin
                adD = {ioExt_q[31:25], a[29:8], low_ad(a)};
            end
            burstD = (sz == SZ_LONG) && (ofs == OFS_QUAD);
        end else if (a[39:29] == TOP_CFG) begin
            cycleD = cpuReq.write ? CYC_CFG_WR : CYC_CFG_RD;
            adD = {8'h00, a[28:7], cfgType_q};
            if (cfgType_q == CFG_TYPE0) begin
                adD[31:11] = 21'h0;
                if (a[20:16] <= IDSEL_MAX) begin
                    adD[31:11] = 21'(21'h1 << a[20:16]);
                end
            end
        end else if (a[39:29] == TOP_SPC) begin
            cycleD = cpuReq.write ? CYC_SPECIAL : CYC_INTACK;
            adD = 32'h0;
            beD = BE_ALL;
        end else if (a[39:30] == TOP_REG_LO) begin
            cycleD = CYC_LOCAL;
        end
    end

    // ------------------------------------------------------------
    // PCI cycle and local access outputs
    // ------------------------------------------------------------
    // Registered outputs, one cycle after the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pciCycle <= '0;
        end else begin
            pciCycle.valid <= cpuReq.valid && cycleD != CYC_NONE && cycleD != CYC_LOCAL;
            pciCycle.cycle <= cycleD;
            pciCycle.ad <= adD;
            pciCycle.byteEnN <= beD;
            pciCycle.burst2 <= burstD;
            pciCycle.data <= cpuReq.data;
        end
    end

    // Register-range decode; reserved codes flag an error
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            localAccess <= '0;
            decodeError <= 1'b0;
        end else begin
            localAccess.valid <= 1'b0;
            decodeError <= cpuReq.valid && cycleD == CYC_NONE;
            localAccess.lwAddr <= a[27:6];
            localAccess.write <= cpuReq.write;
            localAccess.data <= cpuReq.data;
            localAccess.region <= LREG_RSVD;
            if (cpuReq.valid && cycleD == CYC_LOCAL) begin
                if (a[5:0] != 6'h00) begin
                    decodeError <= 1'b1;
                end else if (a[39:28] == REG_CTRL) begin
                    localAccess.valid <= 1'b1;
                    localAccess.region <= LREG_CTRL;
                end else if (a[39:28] == REG_MEMC) begin
                    localAccess.valid <= 1'b1;
                    localAccess.region <= LREG_MEMC;
                end else if (a[39:28] == REG_XLAT) begin
                    localAccess.valid <= 1'b1;
                    localAccess.region <= LREG_XLAT;
                end else begin
                    decodeError <= 1'b1;
                end
            end
        end
    end

    // Interrupt acknowledge vector returned to the processor
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpuReadData <= 32'h0;
            cpuReadValid <= 1'b0;
        end else begin
            cpuReadValid <= intAckValid;
            if (intAckValid) begin
                cpuReadData <= intAckVector;
            end
        end
    end

    // Last-cycle status for software
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lastAd_q <= 32'h0;
            lastCycle_q <= CYC_NONE;
            lastBurst_q <= 1'b0;
            lastBe_q <= BE_ALL;
        end else if (cpuReq.valid) begin
            lastAd_q <= adD;
            lastCycle_q <= cycleD;
            lastBurst_q <= burstD;
            lastBe_q <= beD;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;

    // Captures address and data in either order
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
        end else if (awHeld_q && wHeld_q) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memExt_q <= RST_EXT;
            ioExt_q <= RST_EXT;
            cfgType_q <= CFG_TYPE0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (awHeld_q && wHeld_q) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (awAddr_q == A_MEM_EXT) begin
                memExt_q <= apply_strb(memExt_q, wData_q, wStrb_q);
            end else if (awAddr_q == A_IO_EXT) begin
                ioExt_q <= apply_strb(ioExt_q, wData_q, wStrb_q);
            end else if (awAddr_q == A_CTRL) begin
                if (wStrb_q[0]) begin
                    cfgType_q <= wData_q[1:0];
                end
            end else if (awAddr_q != A_RESULT && awAddr_q != A_CFGSEL) begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Read mux
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
            if (s_axi_araddr == A_MEM_EXT) begin
                s_axi_rdata <= memExt_q;
            end else if (s_axi_araddr == A_IO_EXT) begin
                s_axi_rdata <= ioExt_q;
            end else if (s_axi_araddr == A_CTRL) begin
                s_axi_rdata <= {30'h0, cfgType_q};
            end else if (s_axi_araddr == A_RESULT) begin
                s_axi_rdata <= 32'(lastCycle_q) | (32'(lastBurst_q) << RES_BURST_BIT)
                               | (32'(lastBe_q) << RES_BE_LSB);
            end else if (s_axi_araddr == A_CFGSEL) begin
                s_axi_rdata <= lastAd_q;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : spm_mapper

// ===== src/spm_pkg.sv
package spm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CPU_AW = 40;
    localparam int unsigned AXI_AW = 8;

    // ------------------------------------------------------------
    // Processor address decode constants
    // ------------------------------------------------------------
    localparam logic [5:0] TOP_MEM_R1 = 6'h20;      // addr<39:34> of region 1
    localparam logic [7:0] TOP_MEM_R2 = 8'h84;      // addr<39:32> of region 2
    localparam logic [8:0] TOP_MEM_R3 = 9'h10A;     // addr<39:31> of region 3
    localparam logic [8:0] TOP_IO = 9'h10B;         // addr<39:31> of sparse I/O
    localparam logic [4:0] IO_REGION_A = 5'h16;     // addr<34:30>
    localparam logic [4:0] IO_REGION_B = 5'h17;
    localparam logic [10:0] TOP_CFG = 11'h438;      // addr<39:29>
    localparam logic [10:0] TOP_SPC = 11'h439;
    localparam logic [9:0] TOP_REG_LO = 10'h21D;    // addr<39:30> = 87.4..87.7
    localparam logic [11:0] REG_CTRL = 12'h874;     // addr<39:28>
    localparam logic [11:0] REG_MEMC = 12'h875;
    localparam logic [11:0] REG_XLAT = 12'h876;

    // ------------------------------------------------------------
    // Size field (addr<4:3>) and configuration type codes
    // ------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_TRI = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
    localparam logic [1:0] OFS_QUAD = 2'h3;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    localparam logic [1:0] CFG_TYPE1 = 2'h1;
    localparam logic [4:0] IDSEL_MAX = 5'h14;
    localparam logic [3:0] BE_ALL = 4'h0;

    // ------------------------------------------------------------
    // AXI4-Lite register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_MEM_EXT = 8'h00;
    localparam logic [7:0] A_IO_EXT = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_RESULT = 8'h0C;
    localparam logic [7:0] A_CFGSEL = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RST_EXT = 32'h0000_0000;

    // Result register fields
    localparam int unsigned RES_CYC_LSB = 0;
    localparam int unsigned RES_BURST_BIT = 4;
    localparam int unsigned RES_BE_LSB = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CYC_NONE,
        CYC_MEM_RD,
        CYC_MEM_WR,
        CYC_IO_RD,
        CYC_IO_WR,
        CYC_CFG_RD,
        CYC_CFG_WR,
        CYC_SPECIAL,
        CYC_INTACK,
        CYC_LOCAL
    } spm_cycle_e;

    typedef enum logic [1:0] {
        LREG_CTRL,
        LREG_MEMC,
        LREG_XLAT,
        LREG_RSVD
    } spm_lreg_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [CPU_AW-1:0] addr;
        logic [63:0] data;
    } spm_req_s;

    typedef struct packed {
        logic valid;
        spm_cycle_e cycle;
        logic [31:0] ad;
        logic [3:0] byteEnN;
        logic burst2;
        logic [63:0] data;
    } spm_pci_s;

    typedef struct packed {
        logic valid;
        spm_lreg_e region;
        logic [21:0] lwAddr;
        logic write;
        logic [63:0] data;
    } spm_local_s;

endpackage : spm_pkg

// ===== testbench/spm_isa_model.sv
`timescale 1ns/1ns
module spm_isa_model
    import spm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire spm_pci_s pciCycle,
    input wire logic [31:0] vec,
    input wire logic [3:0] lag,
    output logic [31:0] intAckVector,
    output logic intAckValid
);
    logic [4:0] waitQ;
    // Answer an acknowledge cycle lag cycles late; idle vector lines churn
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitQ <= 5'h00;
            intAckValid <= 1'b0;
            intAckVector <= 32'h0000_0000;
        end else begin
            if (pciCycle.valid && pciCycle.cycle == CYC_INTACK) begin
                waitQ <= {1'b0, lag} + 5'h01;
            end else if (waitQ != 5'h00) begin
                waitQ <= waitQ - 5'h01;
            end
            intAckValid <= (waitQ == 5'h01);
            intAckVector <= (waitQ == 5'h01) ? vec : ~intAckVector;
        end
    end
endmodule : spm_isa_model

// ===== testbench/spm_mapper_props.sv
`timescale 1ns/1ns
module spm_mapper_props
    import spm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire spm_req_s cpuReq,
    input wire logic [31:0] intAckVector,
    input wire logic intAckValid,
    input wire spm_pci_s pciCycle,
    input wire spm_local_s localAccess,
    input wire logic [31:0] cpuReadData,
    input wire logic cpuReadValid,
    input wire logic decodeError
);
    // ----------------------------------------------------------------
    // Request classes
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [39:0] a;
    // Processor address under decode
    assign a = cpuReq.addr;
    sequence ioReq;
        cpuReq.valid && a[39:31] == TOP_IO;
    endsequence
    sequence spcReq;
        cpuReq.valid && a[39:29] == TOP_SPC;
    endsequence
    // ----------------------------------------------------------------
    // Cycle checks
    // ----------------------------------------------------------------
    memR1_a: assert property (cpuReq.valid && a[39:34] == TOP_MEM_R1
        |=> pciCycle.valid && pciCycle.ad[28:3] == $past(a[33:8]))
        else $error("region 1 address wrong");
    memR2_a: assert property (cpuReq.valid && a[39:32] == TOP_MEM_R2
        |=> pciCycle.valid && pciCycle.ad[26:3] == $past(a[31:8]))
        else $error("region 2 address wrong");
    ioRead_a: assert property (ioReq ##0 !cpuReq.write
        |=> pciCycle.valid && pciCycle.cycle == CYC_IO_RD)
        else $error("io read cycle wrong");
    ioRegA_a: assert property (ioReq ##0 a[34:30] == IO_REGION_A
        |=> pciCycle.ad[31:3] == {7'h00, $past(a[29:8])})
        else $error("io region A address wrong");
    ioByte_a: assert property (ioReq ##0 a[4:3] == SZ_BYTE
        |=> pciCycle.ad[2:0] == $past(a[7:5]) && pciCycle.byteEnN == ~(4'h1 << $past(a[6:5])))
        else $error("io byte lane wrong");
    ioQuad_a: assert property (ioReq ##0 a[6:3] == 4'hF
        |=> pciCycle.burst2 && pciCycle.ad[2:0] == 3'h0 && pciCycle.byteEnN == BE_ALL)
        else $error("io quadword burst wrong");
    cfgAddr_a: assert property (cpuReq.valid && a[39:29] == TOP_CFG
        |=> pciCycle.cycle == ($past(cpuReq.write) ? CYC_CFG_WR : CYC_CFG_RD)
            && pciCycle.ad[10:2] == $past(a[15:7]))
        else $error("config cycle wrong");
    spcCyc_a: assert property (spcReq
        |=> pciCycle.cycle == ($past(cpuReq.write) ? CYC_SPECIAL : CYC_INTACK)
            && pciCycle.ad == 32'h0000_0000
            && (!$past(cpuReq.write) || pciCycle.data == $past(cpuReq.data)))
        else $error("special cycle wrong");
    ackData_a: assert property (intAckValid
        |=> cpuReadValid && cpuReadData == $past(intAckVector))
        else $error("vector not returned");
    regLocal_a: assert property (cpuReq.valid && a[39:28] == REG_CTRL
        && a[5:0] == 6'h00 |=> localAccess.valid && localAccess.region == LREG_CTRL
            && localAccess.lwAddr == $past(a[27:6]) && !pciCycle.valid)
        else $error("local register access wrong");
    oneKind_a: assert property (cpuReq.valid
        |=> $onehot({pciCycle.valid, localAccess.valid, decodeError}))
        else $error("not exactly one outcome");
endmodule : spm_mapper_props

bind spm_mapper spm_mapper_props props (.*);

// ===== testbench/spm_mapper_tb_top.sv
`timescale 1ns/1ns
module spm_mapper_tb_top
    import spm_pkg::*;
;
    localparam int LIM = 40;
    localparam logic [31:0] MEM_EXT = 32'hA000_A8B4;
    localparam logic [31:0] IO_EXT = 32'hB400_0000;
    localparam logic [21:0] IO_LOW = 22'h2A_5A5C;
    localparam logic [63:0] DATA = 64'hC3A5_0F1E_7B2D_4C96;
    localparam logic [4:0] IDS [6] = '{5'h00, 5'h01, 5'h13, 5'h14, 5'h15, 5'h1F};
    logic clk, reset_n, intAckValid, cpuReadValid, decodeError;
    spm_req_s cpuReq;
    spm_pci_s pciCycle;
    spm_local_s localAccess;
    logic [31:0] intAckVector, cpuReadData, vec, s_axi_wdata, s_axi_rdata;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb, lag;
    logic [39:0] a;
    int error_cnt, compares, n;

    // Clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    spm_mapper DUT (.*);
    spm_isa_model partner (.*);

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic limit(input int k);
        if (k >= LIM) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no answer in time", $time);
            summarize();
        end
    endtask : limit

    task automatic axiWr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (n = 0; n < LIM && s_axi_bvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        limit(n);
        chk(s_axi_bresp, rsp);
    endtask : axiWr

    task automatic axiRd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge clk);
        s_axi_araddr <= ad;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (n = 0; n < LIM && s_axi_rvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        limit(n);
        chk({s_axi_rresp, s_axi_rdata}, {rsp, d});
    endtask : axiRd

    task automatic cpu(input logic w, input logic [39:0] ad);
        @(posedge clk);
        cpuReq <= '{1'b1, w, ad, DATA};
        @(posedge clk);
        cpuReq.valid <= 1'b0;
        #1;
    endtask : cpu

    task automatic pci(input spm_cycle_e c, input logic [31:0] ad, input logic [3:0] be,
                       input logic b);
        chk({pciCycle.valid, pciCycle.cycle, pciCycle.burst2, pciCycle.byteEnN}, {1'b1, c, b, be});
        chk(pciCycle.ad, ad);
    endtask : pci

    function automatic logic [3:0] beOf(input logic [1:0] sz, input logic [1:0] ofs);
        logic [3:0] m;
        m = (sz == SZ_BYTE) ? 4'h1 : (sz == SZ_WORD) ? 4'h3 : 4'h7;
        return (sz == SZ_LONG) ? BE_ALL : ~(m << ofs);
    endfunction : beOf

    task automatic memAcc(input logic w, input logic [39:0] ad, input logic [5:0] hi);
        cpu(w, ad);
        pci(w ? CYC_MEM_WR : CYC_MEM_RD, {hi, ad[30:8], ad[7], 2'b00}, beOf(ad[4:3], ad[6:5]), 1'b0);
    endtask : memAcc

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        cpuReq = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        vec = 32'h5A3C_00A7;
        lag = 4'h0;
        error_cnt = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // Register defaults, programming and an unmapped offset
        axiRd(A_MEM_EXT, RST_EXT, RESP_OKAY);
        axiRd(A_CTRL, 32'h0000_0000, RESP_OKAY);
        axiWr(A_MEM_EXT, MEM_EXT, RESP_OKAY);
        axiWr(A_IO_EXT, IO_EXT, RESP_OKAY);
        axiRd(A_IO_EXT, IO_EXT, RESP_OKAY);
        axiWr(8'h20, 32'h0000_0000, RESP_SLVERR);
        axiRd(8'h20, 32'h0000_0000, RESP_SLVERR);
        // Sparse memory regions
        memAcc(1'b0, 40'h83_9ABC_DE28, {MEM_EXT[31:29], 3'b111});
        memAcc(1'b1, 40'h84_9ABC_DE28, {MEM_EXT[15:11], 1'b1});
        memAcc(1'b0, 40'h85_1ABC_DEA0, MEM_EXT[7:2]);
        // Every listed size and offset, region A read then region B write
        for (int sz = 0; sz < 4; sz++) begin
            for (int of = 0; of < 4; of++) begin
                if ((sz < 3 && of + sz <= 3) || (sz == 3 && of % 3 == 0)) begin
                    a = {8'h85, 2'b10, IO_LOW, 1'b1, 2'(of), 2'(sz), 3'b000};
                    cpu(1'b0, a);
                    pci(CYC_IO_RD, {7'h00, IO_LOW, (sz == 3 && of == 3) ? 3'b000 : {1'b1, 2'(of)}},
                        beOf(2'(sz), 2'(of)), sz == 3 && of == 3);
                    a[30] = 1'b1;
                    cpu(1'b1, a);
                    pci(CYC_IO_WR, {IO_EXT[31:25], IO_LOW, (sz == 3 && of == 3) ? 3'b000 : {1'b1, 2'(of)}},
                        beOf(2'(sz), 2'(of)), sz == 3 && of == 3);
                end
            end
        end
        axiRd(A_RESULT, {20'h0_0000, BE_ALL, 3'b000, 1'b1, CYC_IO_WR}, RESP_OKAY);
        axiWr(A_CFGSEL, 32'hFFFF_FFFF, RESP_OKAY);
        axiRd(A_CFGSEL, {IO_EXT[31:25], IO_LOW, 3'b000}, RESP_OKAY);
        // Type 0 device selects, including codes that select nothing
        foreach (IDS[i]) begin
            a = {TOP_CFG, 8'h00, IDS[i], 16'h8A18};
            cpu(i[0], a); // probes raise no fill error here
            pci(i[0] ? CYC_CFG_WR : CYC_CFG_RD, {(IDS[i] <= IDSEL_MAX) ? 21'h1 << IDS[i] : 21'h0,
                a[15:7], 2'b00}, BE_ALL, 1'b0);
        end
        // Type 1 and the reserved type codes
        for (int t = 1; t < 4; t++) begin
            axiWr(A_CTRL, 32'(t), RESP_OKAY);
            a = {TOP_CFG, 29'h0ABC_DEC0};
            cpu(1'b0, a);
            pci(CYC_CFG_RD, {8'h00, a[28:7], 2'(t)}, 4'hB, 1'b0);
        end
        // Quadword configuration read of a quadword-aligned register
        a = {TOP_CFG, 29'h0ABC_DE78};
        cpu(1'b0, a);
        pci(CYC_CFG_RD, {8'h00, a[28:7], 2'h3}, BE_ALL, 1'b0);
        // Special cycle carries the message longword untouched
        cpu(1'b1, {TOP_SPC, 29'h0000_1040});
        pci(CYC_SPECIAL, 32'h0000_0000, BE_ALL, 1'b0);
        chk(pciCycle.data, DATA);
        // Interrupt acknowledge, prompt and slow vector source
        for (int l = 0; l < 6; l += 5) begin
            lag <= 4'(l);
            cpu(1'b0, {TOP_SPC, 29'h0000_0000});
            pci(CYC_INTACK, 32'h0000_0000, BE_ALL, 1'b0);
            for (n = 0; n < LIM && cpuReadValid !== 1'b1; n++) begin
                @(posedge clk);
                #1;
            end
            limit(n);
            chk(cpuReadData, vec);
        end
        // Register range: three regions, reserved, misaligned, then an unmapped address
        for (int k = 0; k < 4; k++) begin
            a = {8'h87, 4'(4 + k), 28'h123_4540};
            cpu(k[0], a);
            chk({localAccess.valid, decodeError, pciCycle.valid}, {k < 3, k == 3, 1'b0});
            if (k < 3) chk({localAccess.write, localAccess.region, localAccess.lwAddr},
                           {k[0], 2'(k), a[27:6]});
        end
        cpu(1'b0, 40'h87_4123_4544);
        chk({localAccess.valid, decodeError}, 2'b01);
        cpu(1'b0, 40'h86_0000_0000);
        chk({pciCycle.valid, localAccess.valid, decodeError}, 3'b001);
        summarize();
    end
endmodule : spm_mapper_tb_top
